// >>> dv/cgrb_bank_tb.sv
// Bench for the color gain bank: reset codes, rewrites, reads, gains.
// Assumes the host model carries all register traffic.
`timescale 1ns/100ps
module cgrb_bank_tb;
    import cgrb_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    cgrb_gain_mode_e gain_mode = CGRB_RAW_GAIN_MODE;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data, rd;
    logic reg_wr_en, reg_rd_en, reg_rd_hit, hit;
    logic [5:0] codes [4];
    logic [5:0] ec [4];
    logic [18:0] gains [4];
    logic [7:0] wv [4] = '{8'hff, 8'h5f, 8'h20, 8'h00};
    int n_mismatch = 0;
    int tests_run = 0;

    cgrb_bank i_dut (.clk, .reset_n, .reg_addr, .reg_wr_en, .reg_wr_data,
        .reg_rd_en, .gain_mode, .reg_rd_data, .reg_rd_hit,
        .first_color_code(codes[0]), .second_color_code(codes[1]),
        .third_color_code(codes[2]), .fourth_color_code(codes[3]),
        .first_color_gain(gains[0]), .second_color_gain(gains[1]),
        .third_color_gain(gains[2]), .fourth_color_gain(gains[3]));
    cgrb_host i_host (.clk, .reg_rd_data, .reg_rd_hit, .reg_addr,
        .reg_wr_en, .reg_wr_data, .reg_rd_en);

    initial forever #25 clk = ~clk;

    task automatic chk(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s exp %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Curves in units of 1e-5; linear modes share one white-balance curve
    function automatic logic [31:0] exp_gain(input logic [5:0] c, input int m);
        if (m != 0)
            return 32'h0001_0f7c + 32'h0000_10fe * c;
        return (c < 6'h20) ? 32'h0001_0f7c + 32'h0000_087f * c
            : 32'h0002_0e5e + 32'h0000_10fe * (c - 6'h1f);
    endfunction : exp_gain

    task automatic check_all(input int m);
        gain_mode = cgrb_gain_mode_e'(m);
        repeat (2) @(negedge clk);
        for (int i = 0; i < 4; i++)
        begin
            chk("code", 32'(codes[i]), 32'(ec[i]));
            chk("gain", 32'(gains[i]), exp_gain(ec[i], m));
            i_host.rd(8'(i), rd, hit);
            chk("rd_data", 32'(rd), 32'(ec[i]));
            chk("rd_hit", 32'(hit), 32'h0000_0001);
        end
        i_host.idle();
    endtask : check_all

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    initial
    begin
        ec = '{4{6'h0e}};
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        check_all(0);
        check_all(1);
        for (int i = 0; i < 4; i++)
        begin
            i_host.wr(8'(i), wv[i]);
            ec[i] = wv[i][5:0];
        end
        i_host.wrrd(CGRB_COLOR2_OFS, 8'h2a, rd, hit);
        chk("rw_old_data", 32'(rd), 32'h0000_001f);
        chk("rw_hit", 32'(hit), 32'h0000_0001);
        ec[1] = 6'h2a;
        i_host.idle();
        for (int m = 0; m < 4; m++)
            check_all(m);
        i_host.wr(8'h04, 8'h15);
        i_host.wr(CGRB_GAIN_MODE_OFS, 8'h01);
        i_host.rd(CGRB_GAIN_MODE_OFS, rd, hit);
        i_host.idle();
        chk("unmapped_data", 32'(rd), 32'h0000_0000);
        chk("unmapped_hit", 32'(hit), 32'h0000_0000);
        check_all(2);
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        ec = '{4{6'h0e}};
        check_all(2);
        give_verdict();
    end
endmodule : cgrb_bank_tb

// >>> dv/cgrb_host.sv
// Host model issuing single-cycle register writes and reads.
// Assumes every task is entered at a falling clock edge.
`timescale 1ns/100ps
module cgrb_host
(
    input wire logic clk,
    input wire logic [7:0] reg_rd_data,
    input wire logic reg_rd_hit,
    output logic [7:0] reg_addr = 8'h00,
    output logic reg_wr_en = 1'b0,
    output logic [7:0] reg_wr_data = 8'h00,
    output logic reg_rd_en = 1'b0
);
    // Strobes stay up so that calls may follow back to back
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wr_data = d;
        reg_rd_en = 1'b0;
        reg_wr_en = 1'b1;
        @(negedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
        output logic h);
        reg_addr = a;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b1;
        @(negedge clk);
        d = reg_rd_data;
        h = reg_rd_hit;
    endtask : rd
    // Write and read one offset in the same cycle
    task automatic wrrd(input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] q, output logic h);
        reg_addr = a;
        reg_wr_data = d;
        reg_wr_en = 1'b1;
        reg_rd_en = 1'b1;
        @(negedge clk);
        q = reg_rd_data;
        h = reg_rd_hit;
    endtask : wrrd
    // Released lines flip so a stale value never passes as current
    task automatic idle;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = ~reg_addr;
        reg_wr_data = ~reg_wr_data;
        @(negedge clk);
    endtask : idle
endmodule : cgrb_host

// >>> verilog/cgrb_bank.sv
// Four color white-balance gain code registers with gain evaluation.
// Assumes single-cycle read and write strobes from the serial control slave
// and a gain mode input held by the mode register outside this bank.
`timescale 1ns/100ps
module cgrb_bank
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_en,
    input wire cgrb_pkg::cgrb_gain_mode_e gain_mode,
    output logic [7:0] reg_rd_data,
    output logic reg_rd_hit,
    output logic [5:0] first_color_code,
    output logic [5:0] second_color_code,
    output logic [5:0] third_color_code,
    output logic [5:0] fourth_color_code,
    output logic [18:0] first_color_gain,
    output logic [18:0] second_color_gain,
    output logic [18:0] third_color_gain,
    output logic [18:0] fourth_color_gain
);
    import cgrb_pkg::*;

    logic [5:0] code_reg [CGRB_NUM_COLORS];
    logic [18:0] gain_reg [CGRB_NUM_COLORS];
    logic [7:0] rd_data_reg;
    logic rd_data_next_hit;
    logic rd_hit_reg;
    wire logic addr_in_bank;
    wire logic [1:0] addr_idx;
    wire logic [7:0] rd_data_next;

    // Only the low two address bits select once the upper six are zero
    assign addr_in_bank = (reg_addr & ~8'h03) == CGRB_COLOR1_OFS;
    assign addr_idx = reg_addr[1:0];
    assign rd_data_next = addr_in_bank ?
        {2'h0, code_reg[addr_idx]} : 8'h00;
    assign rd_data_next_hit = reg_rd_en && addr_in_bank;

    genvar gi;
    generate
        for (gi = 0; gi < CGRB_NUM_COLORS; gi++)
        begin : g_color
            wire logic wr_hit;
            wire logic [18:0] code_w;
            wire logic [18:0] gain_raw;
            wire logic [18:0] gain_lin;
            wire logic [18:0] gain_next;

            assign wr_hit = reg_wr_en && addr_in_bank
                && addr_idx == 2'(gi);
            assign code_w = {13'h0000, code_reg[gi]};
            // Raw curve bends at code 32 to a steeper slope
            assign gain_raw = code_reg[gi][5] ?
                CGRB_RAW_KNEE_BASE
                    + CGRB_LIN_STEP * (code_w - CGRB_RAW_KNEE_CODE) :
                CGRB_GAIN_BASE + CGRB_RAW_STEP * code_w;
            assign gain_lin = CGRB_GAIN_BASE + CGRB_LIN_STEP * code_w;
            // Second linear mode only reshapes the exposure stage, so the
            // white-balance stage keeps the first linear curve there
            assign gain_next = (gain_mode == CGRB_RAW_GAIN_MODE) ?
                gain_raw : gain_lin;

            always_ff @(posedge clk)
            begin
                if (!reset_n)
                    code_reg[gi] <= CGRB_CODE_RESET;
                else if (wr_hit)
                    code_reg[gi] <= reg_wr_data[5:0];
            end

            // Reset gain matches the default code in the reset raw mode
            always_ff @(posedge clk)
            begin
                if (!reset_n)
                    gain_reg[gi] <= CGRB_GAIN_UNITY_RAW;
                else
                    gain_reg[gi] <= gain_next;
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            rd_data_reg <= 8'h00;
            rd_hit_reg <= 1'b0;
        end
        else
        begin
            rd_data_reg <= reg_rd_en ? rd_data_next : 8'h00;
            rd_hit_reg <= rd_data_next_hit;
        end
    end

    assign reg_rd_data = rd_data_reg;
    assign reg_rd_hit = rd_hit_reg;
    // Fixed color order of the filter array tile
    assign first_color_code = code_reg[0];
    assign second_color_code = code_reg[1];
    assign third_color_code = code_reg[2];
    assign fourth_color_code = code_reg[3];
    assign first_color_gain = gain_reg[0];
    assign second_color_gain = gain_reg[1];
    assign third_color_gain = gain_reg[2];
    assign fourth_color_gain = gain_reg[3];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    property p_reset_default;
        $past(!reset_n) |-> first_color_code == CGRB_CODE_RESET
            && second_color_code == CGRB_CODE_RESET
            && third_color_code == CGRB_CODE_RESET
            && fourth_color_code == CGRB_CODE_RESET;
    endproperty
    a_reset_default: assert property (p_reset_default)
        else $error("color code not at default after reset");

    property p_write_first;
        reg_wr_en && reg_addr == CGRB_COLOR1_OFS
            |=> first_color_code == $past(reg_wr_data[5:0]);
    endproperty
    a_write_first: assert property (p_write_first)
        else $error("write to first color code not stored");

    property p_hold_codes;
        !reg_wr_en |=> $stable(first_color_code)
            && $stable(second_color_code) && $stable(third_color_code)
            && $stable(fourth_color_code);
    endproperty
    a_hold_codes: assert property (p_hold_codes)
        else $error("color code changed without a write");

    property p_map_fourth;
        reg_wr_en && reg_addr == CGRB_COLOR4_OFS
            |=> fourth_color_code == $past(reg_wr_data[5:0])
            && $stable(first_color_code) && $stable(second_color_code)
            && $stable(third_color_code);
    endproperty
    a_map_fourth: assert property (p_map_fourth)
        else $error("write to offset 3 reached the wrong color");

    property p_read_back;
        reg_rd_en && reg_addr == CGRB_COLOR3_OFS && !reg_wr_en
            |=> reg_rd_hit && reg_rd_data == {2'h0, third_color_code};
    endproperty
    a_read_back: assert property (p_read_back)
        else $error("read of third color code wrong");

    property p_upper_zero;
        (reg_rd_data & CGRB_UNUSED_MASK) == 8'h00;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("unused read bits not zero");

    property p_unity_raw;
        first_color_code == CGRB_CODE_RESET
            && gain_mode == CGRB_RAW_GAIN_MODE
            |=> first_color_gain == CGRB_GAIN_UNITY_RAW;
    endproperty
    a_unity_raw: assert property (p_unity_raw)
        else $error("default code not unity gain in raw mode");

    property p_default_first_linear_gain_mode;
        second_color_code == CGRB_CODE_RESET
            && gain_mode == CGRB_FIRST_LINEAR_GAIN_MODE
            |=> second_color_gain == CGRB_GAIN_DEFAULT_FIRST_LINEAR_GAIN_MODE;
    endproperty
    a_default_first_linear_gain_mode: assert property (p_default_first_linear_gain_mode)
        else $error("default code not 1.3 gain in first linear mode");

    // Writes outside the bank, such as to the mode register, change nothing
    property p_write_ignored;
        reg_wr_en && reg_addr[7:2] != 6'h00
            |=> $stable(first_color_code) && $stable(second_color_code)
            && $stable(third_color_code) && $stable(fourth_color_code);
    endproperty
    a_write_ignored: assert property (p_write_ignored)
        else $error("write outside the bank changed a color code");

    property p_write_third;
        reg_wr_en && reg_addr == CGRB_COLOR3_OFS
            |=> third_color_code == $past(reg_wr_data[5:0]);
    endproperty
    a_write_third: assert property (p_write_third)
        else $error("write to offset 2 not stored in third color code");

    property p_read_miss;
        reg_rd_en && reg_addr[7:2] != 6'h00
            |=> !reg_rd_hit && reg_rd_data == 8'h00;
    endproperty
    a_read_miss: assert property (p_read_miss)
        else $error("read outside the bank returned data");

    // Read data stands one cycle only, so a stale byte never looks fresh
    property p_read_idle;
        !reg_rd_en |=> !reg_rd_hit && reg_rd_data == 8'h00;
    endproperty
    a_read_idle: assert property (p_read_idle)
        else $error("read data present without a read");

    // A read racing a write to the same offset returns the old code
    property p_read_old;
        reg_rd_en && reg_wr_en && reg_addr == CGRB_COLOR2_OFS
            |=> reg_rd_data == {2'h0, $past(second_color_code)};
    endproperty
    a_read_old: assert property (p_read_old)
        else $error("read during write did not return the old code");

    // Second linear mode keeps the first linear white-balance curve
    property p_second_linear;
        third_color_code == CGRB_CODE_RESET
            && gain_mode == CGRB_SECOND_LINEAR_GAIN_MODE
            |=> third_color_gain == CGRB_GAIN_DEFAULT_FIRST_LINEAR_GAIN_MODE;
    endproperty
    a_second_linear: assert property (p_second_linear)
        else $error("default code gain wrong in second linear mode");
endmodule : cgrb_bank

// >>> verilog/cgrb_pkg.sv
// Constants for the color white-balance gain register bank.
// Assumes a serial control slave outside that decodes host transfers into
// single-cycle register reads and writes on the sensor system clock.
package cgrb_pkg;
    localparam int CGRB_NUM_COLORS = 4;
    localparam int CGRB_CODE_W = 6;
    localparam int CGRB_GAIN_W = 19;

    // Register offsets; color index equals the offset
    localparam logic [7:0] CGRB_COLOR1_OFS = 8'h00;
    localparam logic [7:0] CGRB_COLOR2_OFS = 8'h01;
    localparam logic [7:0] CGRB_COLOR3_OFS = 8'h02;
    localparam logic [7:0] CGRB_COLOR4_OFS = 8'h03;
    // Mode register lives outside this bank
    localparam logic [7:0] CGRB_GAIN_MODE_OFS = 8'h22;

    localparam logic [5:0] CGRB_CODE_RESET = 6'h0e;
    localparam logic [7:0] CGRB_UNUSED_MASK = 8'hc0;

    typedef enum logic [1:0]
    {
        CGRB_RAW_GAIN_MODE = 2'h0,
        CGRB_FIRST_LINEAR_GAIN_MODE = 2'h1,
        CGRB_SECOND_LINEAR_GAIN_MODE = 2'h2
    } cgrb_gain_mode_e;

    // Gains are in units of 1e-5
    localparam logic [18:0] CGRB_GAIN_BASE = 19'h1_0f7c;
    localparam logic [18:0] CGRB_RAW_STEP = 19'h0_087f;
    localparam logic [18:0] CGRB_RAW_KNEE_BASE = 19'h2_0e5e;
    localparam logic [18:0] CGRB_LIN_STEP = 19'h0_10fe;
    localparam logic [18:0] CGRB_RAW_KNEE_CODE = 19'h0_001f;
    localparam logic [18:0] CGRB_GAIN_UNITY_RAW = 19'h1_866e;
    localparam logic [18:0] CGRB_GAIN_DEFAULT_FIRST_LINEAR_GAIN_MODE = 19'h1_fd60;
endpackage : cgrb_pkg
